// file: shared/tx_test_pkg.sv
// Constants, modes and states for the transmit test pattern generator
package tx_test_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int BIT_TIME_NS = 4000;
    localparam int BIT_CYCLES = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [8:0] BIT_CNT_LAST = 9'(BIT_CYCLES - 1);

    localparam logic [1:0] TXMODE_BUFFER = 2'h2;
    localparam logic [1:0] TXMODE_PSEUDO = 2'h3;

    localparam logic [7:0] PREAMBLE_BYTE = 8'h00;
    localparam logic [7:0] SFD_BYTE = 8'ha7;
    localparam logic [2:0] SFD_INDEX = 3'h4;
    localparam logic [5:0] SHR_LAST_BIT = 6'h27;

    localparam logic [15:0] PN_LAST_BIT = 16'hfffe;
    localparam logic [15:0] BUF_LAST_BIT = 16'h03ff;

    localparam logic [15:0] CRC_SEED = 16'h0000;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [7:0] CRC_FEED = 8'hff;

    localparam logic [15:0] DAC_NO_OVERRIDE = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SYNC = 3'h2,
        ST_DATA = 3'h4
    } txState_t;
endpackage

// file: core/crc_byte_step.sv
// One byte step of the LSB-first CRC-16 used as pattern source
`timescale 1ns/1ps
module crc_byte_step
    import tx_test_pkg::*;
(
    input wire logic [15:0] crcIn,
    input wire logic [7:0] dataIn,
    output logic [15:0] crcOut
);
    function automatic logic [15:0] crcBit(input logic [15:0] c, input logic d);
        crcBit = (c[0] ^ d) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    endfunction

    logic [15:0] stage [0:8];

    assign stage[0] = crcIn;

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : gBit
            assign stage[i + 1] = crcBit(stage[i], dataIn[i]);
        end
    endgenerate

    assign crcOut = stage[8];
endmodule

// file: core/tx_test_pattern_generator.sv
// Transmit test mode sequencer: sync header, then PN or buffer replay
`timescale 1ns/1ps
module tx_test_pattern_generator
    import tx_test_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] txMode,
    input wire logic [15:0] dacOverride,
    input wire logic transmitOnStrobe,
    input wire logic transmitOffStrobe,
    input wire logic oscStable,
    input wire logic [7:0] bufData,
    output logic [6:0] bufAddr,
    output logic txActive,
    output logic txBit,
    output logic bitStrobe,
    output logic dacHold,
    output logic [15:0] dacValue
);
    txState_t state_reg, state_next;
    logic [8:0] divCnt_reg;
    logic [5:0] shrCnt_reg;
    logic [15:0] seqCnt_reg;
    logic [2:0] bitIdx_reg;
    logic [15:0] crc_reg;
    logic [6:0] bufAddr_reg;
    logic pnMode_reg;
    logic txBit_reg;
    logic bitStrobe_reg;
    logic dacHold_reg;
    logic [15:0] dacValue_reg;
    logic txActive_reg;

    logic [15:0] crcStepped;
    wire isIdle = (state_reg == ST_IDLE);
    wire isSync = (state_reg == ST_SYNC);
    wire isData = (state_reg == ST_DATA);
    wire testMode = (txMode == TXMODE_BUFFER) || (txMode == TXMODE_PSEUDO);
    // Strobe without a stable oscillator would start a garbage stream
    wire startTx = isIdle && transmitOnStrobe && oscStable && testMode;
    wire stopTx = !isIdle && transmitOffStrobe;
    wire bitTick = !isIdle && (divCnt_reg == BIT_CNT_LAST);
    wire byteDone = bitTick && (bitIdx_reg == 3'h7);
    wire sfdNow = (shrCnt_reg[5:3] == SFD_INDEX);
    wire shrByte = sfdNow ? SFD_BYTE[bitIdx_reg] : PREAMBLE_BYTE[bitIdx_reg];
    wire shrDone = isSync && bitTick && (shrCnt_reg == SHR_LAST_BIT);
    wire [7:0] dataByte = pnMode_reg ? crc_reg[7:0] : bufData;
    wire [15:0] seqLast = pnMode_reg ? PN_LAST_BIT : BUF_LAST_BIT;
    wire seqDone = isData && bitTick && (seqCnt_reg == seqLast);
    wire outBit = isSync ? shrByte : dataByte[bitIdx_reg];
    // Stop clears the replay state at the stop edge itself, not a cycle later
    wire seqRestart = !isData || seqDone || stopTx;
    wire [5:0] shrCnt_next = isSync ? shrCnt_reg + 6'h01 : shrCnt_reg;
    wire [2:0] bitIdx_next = bitIdx_reg + 3'h1;
    wire [15:0] crc_next = pnMode_reg ? crcStepped : crc_reg;
    wire [6:0] bufAddr_next = pnMode_reg ? bufAddr_reg : bufAddr_reg + 7'h01;

    crc_byte_step uCrc (
        .crcIn(crc_reg),
        .dataIn(CRC_FEED),
        .crcOut(crcStepped)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (startTx) begin
                    state_next = ST_SYNC;
                end
            end
            ST_SYNC: begin
                if (stopTx) begin
                    state_next = ST_IDLE;
                end else if (shrDone) begin
                    state_next = ST_DATA;
                end
            end
            ST_DATA: begin
                if (stopTx) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Bit-rate divider, held in phase with the start strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_reg <= 9'h000;
        end else if (isIdle || bitTick) begin
            divCnt_reg <= 9'h000;
        end else begin
            divCnt_reg <= divCnt_reg + 9'h001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pnMode_reg <= 1'b0;
        end else if (startTx) begin
            pnMode_reg <= (txMode == TXMODE_PSEUDO);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shrCnt_reg <= 6'h00;
        end else if (isIdle || shrDone || seqDone) begin
            shrCnt_reg <= 6'h00;
        end else if (bitTick) begin
            shrCnt_reg <= shrCnt_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bitIdx_reg <= 3'h0;
        end else if (isIdle || shrDone || seqDone) begin
            bitIdx_reg <= 3'h0;
        end else if (bitTick) begin
            bitIdx_reg <= bitIdx_next;
        end
    end

    // PN length is not a byte multiple, so restart resets the bit index too
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seqCnt_reg <= 16'h0000;
        end else if (!isData || seqDone) begin
            seqCnt_reg <= 16'h0000;
        end else if (bitTick) begin
            seqCnt_reg <= seqCnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_reg <= CRC_SEED;
        end else if (seqRestart) begin
            crc_reg <= CRC_SEED;
        end else if (byteDone) begin
            crc_reg <= crc_next;
        end
    end

    // Replay never waits on the buffer, so an underflow cannot stall it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bufAddr_reg <= 7'h00;
        end else if (seqRestart) begin
            bufAddr_reg <= 7'h00;
        end else if (byteDone) begin
            bufAddr_reg <= bufAddr_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txBit_reg <= 1'b0;
            bitStrobe_reg <= 1'b0;
        end else begin
            bitStrobe_reg <= bitTick && !stopTx;
            if (bitTick) begin
                txBit_reg <= outBit;
            end
        end
    end

    // Override sampled at start so a mid-stream write cannot glitch the carrier
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dacHold_reg <= 1'b0;
            dacValue_reg <= DAC_NO_OVERRIDE;
        end else if (startTx) begin
            dacHold_reg <= (dacOverride != DAC_NO_OVERRIDE);
            dacValue_reg <= dacOverride;
        end else if (state_next == ST_IDLE) begin
            dacHold_reg <= 1'b0;
        end
    end

    // Status taken from the next state so it stays in step with the state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txActive_reg <= 1'b0;
        end else begin
            txActive_reg <= (state_next != ST_IDLE);
        end
    end

    assign bufAddr = bufAddr_reg;
    assign txActive = txActive_reg;
    assign txBit = txBit_reg;
    assign bitStrobe = bitStrobe_reg;
    assign dacHold = dacHold_reg;
    assign dacValue = dacValue_reg;
endmodule

// file: dv/tx_test_pattern_generator_assertions.sv
// Port-level checks for the transmit test pattern generator
`timescale 1ns/1ps
module tx_test_pattern_generator_assertions
    import tx_test_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] txMode,
    input wire logic [15:0] dacOverride,
    input wire logic transmitOnStrobe,
    input wire logic transmitOffStrobe,
    input wire logic oscStable,
    input wire logic [6:0] bufAddr,
    input wire logic txActive,
    input wire logic txBit,
    input wire logic bitStrobe,
    input wire logic dacHold,
    input wire logic [15:0] dacValue
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire startTaken = transmitOnStrobe && !txActive && oscStable && txMode[1];
    start_taken_a: assert property (startTaken |=> txActive) else $error("start lost");
    start_refused_a: assert property (
        transmitOnStrobe && !txActive && !startTaken |=> !txActive) else $error("bad start taken");
    stop_clean_a: assert property (
        transmitOffStrobe && txActive |=> !txActive && !dacHold && bufAddr == 7'h00)
        else $error("stop failed");
    dac_load_a: assert property (
        startTaken |=> dacHold == ($past(dacOverride) != 16'h0000)
        && dacValue == $past(dacOverride)) else $error("override not latched");
    dac_static_a: assert property (
        dacHold && $past(dacHold) |-> $stable(dacValue)) else $error("dac moved");
    idle_quiet_a: assert property (
        !txActive && !$past(txActive) |-> !bitStrobe) else $error("bit while idle");
    first_bit_a: assert property (
        startTaken |-> ##[501:501] (bitStrobe && !txBit)) else $error("first bit late");
    bit_period_a: assert property (
        bitStrobe |-> ##[500:500] (bitStrobe || !txActive)) else $error("bit period off");
endmodule

bind tx_test_pattern_generator tx_test_pattern_generator_assertions u_chk (.clk(clk),
    .rst_n(rst_n), .txMode(txMode), .dacOverride(dacOverride),
    .transmitOnStrobe(transmitOnStrobe), .transmitOffStrobe(transmitOffStrobe),
    .oscStable(oscStable), .bufAddr(bufAddr), .txActive(txActive), .txBit(txBit),
    .bitStrobe(bitStrobe), .dacHold(dacHold), .dacValue(dacValue));

// file: dv/tx_buffer_model.sv
// Transmit buffer model, read combinationally by address
`timescale 1ns/1ps
module tx_buffer_model (
    input wire logic [6:0] bufAddr,
    output logic [7:0] bufData
);
    logic [7:0] mem [128];
    assign bufData = mem[bufAddr];
endmodule

// file: dv/tx_test_pattern_generator_tb_top.sv
// Testbench: header and data bit streams checked against a queue
`timescale 1ns/1ps
module tx_test_pattern_generator_tb_top
    import tx_test_pkg::*;
;
    logic clk = 0, rst_n = 0, onStb = 0, offStb = 0, oscOk = 0;
    logic [1:0] mode = 0;
    logic [15:0] dac = 0, dacValue;
    logic [7:0] bufData;
    logic [6:0] bufAddr;
    logic txActive, txBit, bitStrobe, dacHold;
    logic expQ[$];
    int n_fail = 0, num_checks = 0, cyc = 0;
    localparam logic [7:0] PN[7] = '{8'h00, 8'h78, 8'hb8, 8'h4b, 8'h99, 8'hc3, 8'he9};
    always #4 clk = ~clk;
    tx_test_pattern_generator u_tx_test_pattern_generator (.clk(clk), .rst_n(rst_n),
        .txMode(mode), .dacOverride(dac), .transmitOnStrobe(onStb), .transmitOffStrobe(offStb),
        .oscStable(oscOk), .bufData(bufData), .bufAddr(bufAddr), .txActive(txActive),
        .txBit(txBit), .bitStrobe(bitStrobe), .dacHold(dacHold), .dacValue(dacValue));
    tx_buffer_model u_tx_buffer_model (.bufAddr(bufAddr), .bufData(bufData));
    task automatic chk(string what, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic pushByte(logic [7:0] b);
        for (int i = 0; i < 8; i++) expQ.push_back(b[i]);
    endtask
    task automatic run(logic [1:0] m, int nData, logic [15:0] d);
        for (int i = 0; i < 4; i++) pushByte(PREAMBLE_BYTE);
        pushByte(SFD_BYTE);
        for (int i = 0; i < nData; i++) pushByte(m == TXMODE_PSEUDO ? PN[i] : u_tx_buffer_model.mem[i]);
        @(posedge clk) #1 mode = m;
        dac = d;
        onStb = 1;
        @(posedge clk) #1;
        chk("txActive", 16'h0001, 16'(txActive));
        chk("dacHold", 16'(d != 16'h0000), 16'(dacHold));
        chk("dacValue", d, dacValue);
        // Strobe held one more edge: a start while sending must be ignored
        @(posedge clk) #1 onStb = 0;
        for (int t = 0; t < 60000 && expQ.size() != 0; t++) @(posedge clk);
        chk("drained", 0, 16'(expQ.size()));
        @(posedge clk) #1 offStb = 1;
        @(posedge clk) #1 offStb = 0;
        chk("stopped", 0, {txActive, dacHold});
        chk("bufAddr", 0, 16'(bufAddr));
        repeat (600) @(posedge clk);
    endtask
    // Bits are sampled one edge late, after the strobe's own update has settled
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (bitStrobe === 1'b1) begin
            if (expQ.size() == 0) chk("extra bit", 0, 1);
            else chk("txBit", 16'(expQ.pop_front()), 16'(txBit));
        end
        if (cyc == 90000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(7));
        for (int i = 0; i < 128; i++) u_tx_buffer_model.mem[i] = 8'($urandom);
        repeat (6) @(posedge clk);
        #1 rst_n = 1;
        for (int m = 0; m < 4; m++) begin
            @(posedge clk) #1 mode = 2'(m);
            oscOk = (m < 2);
            onStb = 1;
            @(posedge clk) #1 onStb = 0;
            chk("refused", 0, 16'(txActive));
        end
        oscOk = 1;
        run(TXMODE_PSEUDO, 7, 16'h1800);
        run(TXMODE_BUFFER, 3, 16'h0000);
        finish_test();
    end
endmodule
